// ==== shared/gdmp_map.svh ====
// Constants for the gate driver mode and protection block
`ifndef GDMP_MAP_SVH
`define GDMP_MAP_SVH

// ---------------------------------------------------------------
// Clock and times
// ---------------------------------------------------------------
`define GDMP_CLK_MHZ 250
`define GDMP_WAKE_FILT_US 100
`define GDMP_RUN_FILT_US 500
`define GDMP_BLANK_NS 5000
`define GDMP_TRIP_FILT_NS 1000
`define GDMP_OC_FILT_NS 10000
`define GDMP_WAKE_FILT_CYC (`GDMP_WAKE_FILT_US * `GDMP_CLK_MHZ)
`define GDMP_RUN_FILT_CYC (`GDMP_RUN_FILT_US * `GDMP_CLK_MHZ)
`define GDMP_BLANK_CYC ((`GDMP_BLANK_NS * `GDMP_CLK_MHZ + 999) / 1000)
`define GDMP_TRIP_FILT_CYC ((`GDMP_TRIP_FILT_NS * `GDMP_CLK_MHZ) / 1000)
`define GDMP_OC_FILT_CYC ((`GDMP_OC_FILT_NS * `GDMP_CLK_MHZ) / 1000)

// ---------------------------------------------------------------
// Register offsets and fields
// ---------------------------------------------------------------
`define GDMP_OFS_CTRL 12'h000
`define GDMP_OFS_STATUS 12'h004
`define GDMP_OFS_GAIN 12'h008
`define GDMP_CTRL_RST 4'h0
`define GDMP_ST_MODE_LSB 0
`define GDMP_ST_FLAG_LOW 2
`define GDMP_ST_FLAG_HIGH 3
`define GDMP_ST_BRANCH_LSB 4
`define GDMP_ST_OC 7
`define GDMP_ST_GS_UV 8
`define GDMP_ST_VDD_GOOD 9

`endif

// ==== shared/gdmp_pkg.sv ====
// Types for the gate driver mode and protection block
`default_nettype none

package gdmp_pkg;

  typedef enum logic [1:0] {
    GDMP_SLEEP   = 2'b00,
    GDMP_WAKEUP  = 2'b01,
    GDMP_STANDBY = 2'b10,
    GDMP_RUN     = 2'b11
  } gdmp_mode_t;

  typedef logic [17:0] gdmp_cnt_t;

endpackage : gdmp_pkg

`default_nettype wire

// ==== core/gdmp_core.sv ====
// Mode control, gate interlock and protection of the gate driver
`include "gdmp_map.svh"
`default_nettype none

// Contract
// - Power-up in sleep, switch node off, gates low
// - Wake high 100 us before leaving sleep
// - Both flags high during startup, 500 us
// - Sleep after run and wake low 500 us
// - Sleep switches off both regulators
// - Standby while run low, gates off
// - Leave run only after run low 500 us, or at once on overtemp shutdown
// - Wake low in standby leads to sleep
// - Run high keeps device active without wake
// - Standby and sleep: gates low, comparators off
// - Never high and low side together
// - Short monitor enabled 5 us after command
// - Filtered trip disables branch, both flags high
// - Short fault latched until run goes low
// - Gate supply undervoltage: drivers off, low flag
// - Supply reset indication: both flags high
// - Wake-up completes only with gate supply good
// - Sense select: supply, phase 1, 2, 3
// - Gain settings fixed on entering run
// - Flags encode none, uv, temp, short
module gdmp_core #(
  parameter int unsigned WAKE_FILT_CYC = `GDMP_WAKE_FILT_CYC,
  parameter int unsigned RUN_FILT_CYC = `GDMP_RUN_FILT_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic wake_in,
  input wire logic run_req,
  input wire logic [2:0] high_side_cmd,
  input wire logic [2:0] low_side_cmd,
  input wire logic sense_select_bit0,
  input wire logic sense_select_bit1,
  input wire logic gate_supply_uv,
  input wire logic supply_good,
  input wire logic supply_por,
  input wire logic overtemp_warn,
  input wire logic overtemp_off,
  input wire logic overcurrent,
  input wire logic [5:0] drain_source_trip,
  output logic [2:0] high_side_gate_out,
  output logic [2:0] low_side_gate_out,
  output logic [5:0] short_monitor_en,
  output logic fault_flag_low,
  output logic fault_flag_high,
  output logic buck_enable,
  output logic regulator_enable,
  output logic buck_switch_node_hiz,
  output logic [1:0] phase_sense_sel,
  output logic phase_sense_to_gnd,
  output logic [3:0] sense_gain,
  output gdmp_pkg::gdmp_mode_t drive_mode
);
  import gdmp_pkg::*;

  localparam int unsigned NSYNC = 22;
  localparam gdmp_cnt_t WAKE_LIM = gdmp_cnt_t'(WAKE_FILT_CYC);
  localparam gdmp_cnt_t RUN_LIM = gdmp_cnt_t'(RUN_FILT_CYC);
  localparam gdmp_cnt_t BLANK_LIM = gdmp_cnt_t'(`GDMP_BLANK_CYC);
  localparam gdmp_cnt_t TRIP_LIM = gdmp_cnt_t'(`GDMP_TRIP_FILT_CYC);
  localparam gdmp_cnt_t OC_LIM = gdmp_cnt_t'(`GDMP_OC_FILT_CYC);

  function automatic gdmp_cnt_t sat_inc(input gdmp_cnt_t c,
                                        input gdmp_cnt_t lim);
    sat_inc = (c >= lim) ? c : c + 18'h00001;
  endfunction : sat_inc

  // -------------------------------------------------------------
  // Input synchronisers
  // -------------------------------------------------------------
  logic [NSYNC-1:0] sync1_q;
  logic [NSYNC-1:0] sync2_q;
  logic [NSYNC-1:0] raw_in;

  always_comb begin
    raw_in = {overcurrent, drain_source_trip, overtemp_off, overtemp_warn,
              supply_por, supply_good, gate_supply_uv, sense_select_bit1,
              sense_select_bit0, low_side_cmd, high_side_cmd, run_req,
              wake_in};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= raw_in;
      sync2_q <= sync1_q;
    end
  end

  logic wake_s;
  logic run_s;
  logic [5:0] cmd_s;
  logic [1:0] sel_s;
  logic gs_uv_s;
  logic vdd_good_s;
  logic por_s;
  logic otw_s;
  logic oto_s;
  logic [5:0] trip_s;
  logic oc_s;

  always_comb begin
    wake_s = sync2_q[0];
    run_s = sync2_q[1];
    cmd_s = sync2_q[7:2];
    sel_s = sync2_q[9:8];
    gs_uv_s = sync2_q[10];
    vdd_good_s = sync2_q[11];
    por_s = sync2_q[12];
    otw_s = sync2_q[13];
    oto_s = sync2_q[14];
    trip_s = sync2_q[20:15];
    oc_s = sync2_q[21];
  end

  // -------------------------------------------------------------
  // Filter counters and mode machine
  // -------------------------------------------------------------
  gdmp_mode_t mode_q, mode_d;
  gdmp_cnt_t wake_cnt_q, wake_cnt_d;
  gdmp_cnt_t idle_cnt_q, idle_cnt_d;
  gdmp_cnt_t rlow_cnt_q, rlow_cnt_d;
  gdmp_cnt_t start_cnt_q, start_cnt_d;
  logic [3:0] ctrl_q, ctrl_d;
  logic [3:0] gain_q, gain_d;

  always_comb begin
    wake_cnt_d = wake_s ? sat_inc(wake_cnt_q, WAKE_LIM) : '0;
    idle_cnt_d = (!wake_s && !run_s) ? sat_inc(idle_cnt_q, RUN_LIM) : '0;
    rlow_cnt_d = !run_s ? sat_inc(rlow_cnt_q, RUN_LIM) : '0;
    start_cnt_d = (mode_q == GDMP_WAKEUP) ?
                  sat_inc(start_cnt_q, RUN_LIM) : '0;
    mode_d = mode_q;
    gain_d = gain_q;
    unique case (mode_q)
      GDMP_SLEEP: begin
        if (wake_cnt_q >= WAKE_LIM) mode_d = GDMP_WAKEUP;
      end
      GDMP_WAKEUP: begin
        if (oto_s || idle_cnt_q >= RUN_LIM) mode_d = GDMP_SLEEP;
        else if (vdd_good_s && !gs_uv_s && start_cnt_q >= RUN_LIM)
          mode_d = GDMP_STANDBY;
      end
      GDMP_STANDBY: begin
        if (oto_s || idle_cnt_q >= RUN_LIM) mode_d = GDMP_SLEEP;
        else if (run_s) mode_d = GDMP_RUN;
      end
      GDMP_RUN: begin
        if (oto_s) mode_d = GDMP_SLEEP;
        else if (rlow_cnt_q >= RUN_LIM) mode_d = GDMP_STANDBY;
      end
    endcase
    if (mode_q != GDMP_RUN && mode_d == GDMP_RUN) gain_d = ctrl_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= GDMP_SLEEP;
      wake_cnt_q <= '0;
      idle_cnt_q <= '0;
      rlow_cnt_q <= '0;
      start_cnt_q <= '0;
      gain_q <= `GDMP_CTRL_RST;
    end else begin
      mode_q <= mode_d;
      wake_cnt_q <= wake_cnt_d;
      idle_cnt_q <= idle_cnt_d;
      rlow_cnt_q <= rlow_cnt_d;
      start_cnt_q <= start_cnt_d;
      gain_q <= gain_d;
    end
  end

  // -------------------------------------------------------------
  // Gate drive, blanking and short-circuit latch
  // -------------------------------------------------------------
  gdmp_cnt_t blank_q [6];
  gdmp_cnt_t blank_d [6];
  gdmp_cnt_t deb_q [6];
  gdmp_cnt_t deb_d [6];
  gdmp_cnt_t oc_cnt_q, oc_cnt_d;
  logic oc_q, oc_d;
  logic [2:0] branch_q, branch_d;
  logic [5:0] mon_en;
  logic [5:0] hit;
  logic [5:0] gate_q, gate_d;
  logic run_mode;

  always_comb begin
    run_mode = (mode_q == GDMP_RUN);
    for (int i = 0; i < 6; i++) begin
      blank_d[i] = (run_mode && cmd_s[i]) ?
                   sat_inc(blank_q[i], BLANK_LIM) : '0;
      mon_en[i] = run_mode && gate_q[i] && (blank_q[i] >= BLANK_LIM);
      deb_d[i] = (mon_en[i] && trip_s[i]) ? sat_inc(deb_q[i], TRIP_LIM) : '0;
      hit[i] = mon_en[i] && trip_s[i] && (deb_q[i] >= TRIP_LIM);
    end
    oc_cnt_d = (run_mode && oc_s) ? sat_inc(oc_cnt_q, OC_LIM) : '0;
    oc_d = (oc_q && run_s) || (run_mode && oc_cnt_q >= OC_LIM);
    branch_d = (branch_q & {3{run_s}}) | hit[2:0] | hit[5:3];
    for (int p = 0; p < 3; p++) begin
      gate_d[p] = run_mode && !gs_uv_s && !oc_d && !branch_d[p]
                  && cmd_s[p] && !cmd_s[p+3];
      gate_d[p+3] = run_mode && !gs_uv_s && !oc_d && !branch_d[p]
                    && cmd_s[p+3] && !cmd_s[p];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 6; i++) begin
        blank_q[i] <= '0;
        deb_q[i] <= '0;
      end
      oc_cnt_q <= '0;
      oc_q <= 1'b0;
      branch_q <= 3'h0;
      gate_q <= 6'h00;
    end else begin
      for (int i = 0; i < 6; i++) begin
        blank_q[i] <= blank_d[i];
        deb_q[i] <= deb_d[i];
      end
      oc_cnt_q <= oc_cnt_d;
      oc_q <= oc_d;
      branch_q <= branch_d;
      gate_q <= gate_d;
    end
  end

  // -------------------------------------------------------------
  // Fault flags, supplies and sense path
  // -------------------------------------------------------------
  logic [1:0] flags_q, flags_d;
  logic [5:0] mon_q;
  logic [2:0] sup_q, sup_d;
  logic [1:0] sel_q;
  logic gnd_q, gnd_d;

  always_comb begin
    if (mode_q == GDMP_SLEEP) flags_d = 2'h0;
    else if (por_s) flags_d = 2'h3;
    else if (mode_q == GDMP_WAKEUP) flags_d = 2'h3;
    else if (run_mode && (oc_q || (|branch_q))) flags_d = 2'h3;
    else if (otw_s) flags_d = 2'h2;
    else if (gs_uv_s) flags_d = 2'h1;
    else flags_d = 2'h0;
    sup_d = (mode_d == GDMP_SLEEP) ? 3'b100 : 3'b011;
    gnd_d = (sel_s == 2'b00) && !wake_s;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= 2'h0;
      mon_q <= 6'h00;
      sup_q <= 3'b100;
      sel_q <= 2'b00;
      gnd_q <= 1'b1;
    end else begin
      flags_q <= flags_d;
      mon_q <= mon_en;
      sup_q <= sup_d;
      sel_q <= sel_s;
      gnd_q <= gnd_d;
    end
  end

  // -------------------------------------------------------------
  // APB register slave
  // -------------------------------------------------------------
  logic [31:0] rdata_q, rdata_d;
  logic hit_ctrl;
  logic hit_any;
  logic [31:0] status_w;

  always_comb begin
    hit_ctrl = (paddr == `GDMP_OFS_CTRL);
    hit_any = hit_ctrl || (paddr == `GDMP_OFS_STATUS)
              || (paddr == `GDMP_OFS_GAIN);
    status_w = 32'h00000000;
    status_w[`GDMP_ST_MODE_LSB +: 2] = mode_q;
    status_w[`GDMP_ST_FLAG_LOW] = flags_q[0];
    status_w[`GDMP_ST_FLAG_HIGH] = flags_q[1];
    status_w[`GDMP_ST_BRANCH_LSB +: 3] = branch_q;
    status_w[`GDMP_ST_OC] = oc_q;
    status_w[`GDMP_ST_GS_UV] = gs_uv_s;
    status_w[`GDMP_ST_VDD_GOOD] = vdd_good_s;
    ctrl_d = ctrl_q;
    if (psel && penable && pwrite && hit_ctrl) ctrl_d = pwdata[3:0];
    rdata_d = rdata_q;
    if (psel && !penable) begin
      if (paddr == `GDMP_OFS_CTRL) rdata_d = {28'h0000000, ctrl_q};
      else if (paddr == `GDMP_OFS_STATUS) rdata_d = status_w;
      else if (paddr == `GDMP_OFS_GAIN) rdata_d = {28'h0000000, gain_q};
      else rdata_d = 32'h00000000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `GDMP_CTRL_RST;
      rdata_q <= 32'h00000000;
    end else begin
      ctrl_q <= ctrl_d;
      rdata_q <= rdata_d;
    end
  end

  // -------------------------------------------------------------
  // Outputs
  // -------------------------------------------------------------
  always_comb begin
    prdata = rdata_q;
    pready = 1'b1;
    pslverr = psel && penable && !hit_any;
    high_side_gate_out = gate_q[2:0];
    low_side_gate_out = gate_q[5:3];
    short_monitor_en = mon_q;
    fault_flag_low = flags_q[0];
    fault_flag_high = flags_q[1];
    buck_enable = sup_q[0];
    regulator_enable = sup_q[1];
    buck_switch_node_hiz = sup_q[2];
    phase_sense_sel = sel_q;
    phase_sense_to_gnd = gnd_q;
    sense_gain = gain_q;
    drive_mode = mode_q;
  end

endmodule : gdmp_core

`default_nettype wire

// ==== tb/gdmp_assertions.sv ====
// Property checks on the gate driver mode and protection ports
`default_nettype none
module gdmp_assertions #(
  parameter int unsigned WAKE_FILT_CYC = 20,
  parameter int unsigned RUN_FILT_CYC = 50
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wake_in,
  input wire logic run_req,
  input wire logic supply_por,
  input wire logic [2:0] high_side_cmd,
  input wire logic [2:0] high_side_gate_out,
  input wire logic [2:0] low_side_gate_out,
  input wire logic [5:0] short_monitor_en,
  input wire logic fault_flag_low,
  input wire logic fault_flag_high,
  input wire logic buck_enable,
  input wire logic regulator_enable,
  input wire logic buck_switch_node_hiz,
  input wire gdmp_pkg::gdmp_mode_t drive_mode
);
  timeunit 1ns;
  timeprecision 1ps;
  import gdmp_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [1:0] flg;
  assign flg = {fault_flag_high, fault_flag_low};
  gate_lock_a: assert property (
    !(|(high_side_gate_out & low_side_gate_out))) else $error("both sides on");
  idle_off_a: assert property (
    drive_mode != GDMP_RUN && $past(drive_mode) != GDMP_RUN
    |-> {high_side_gate_out, low_side_gate_out, short_monitor_en} == 12'h000)
    else $error("gates or monitors on outside run");
  sleep_off_a: assert property (
    drive_mode == GDMP_SLEEP && $past(drive_mode) == GDMP_SLEEP
    |-> buck_switch_node_hiz && !buck_enable && !regulator_enable
    && flg == 2'h0) else $error("supplies active in sleep");
  wake_flags_a: assert property (
    drive_mode == GDMP_WAKEUP && $past(drive_mode) == GDMP_WAKEUP
    |-> flg == 2'h3 && buck_enable) else $error("startup flags wrong");
  por_flags_a: assert property (
    (supply_por && drive_mode != GDMP_SLEEP)[*4] |-> flg == 2'h3)
    else $error("reset indication not flagged");
  blank_a: assert property (
    $rose(short_monitor_en[0]) |-> $past(high_side_cmd[0], 1200))
    else $error("monitor enabled too early");
  run_hold_a: assert property (
    $past(drive_mode) == GDMP_RUN && drive_mode == GDMP_STANDBY
    |-> !$past(run_req, 3) && !$past(run_req, RUN_FILT_CYC))
    else $error("run left too early");
  wake_filt_a: assert property (
    $past(drive_mode) == GDMP_SLEEP && drive_mode == GDMP_WAKEUP
    |-> $past(wake_in, 4) && $past(wake_in, WAKE_FILT_CYC))
    else $error("wake not filtered");
  sleep_entry_a: assert property (
    $past(drive_mode) != GDMP_SLEEP && drive_mode == GDMP_SLEEP
    |-> !$past(run_req, 3) && !$past(wake_in, RUN_FILT_CYC))
    else $error("sleep entered too early");
endmodule : gdmp_assertions
`default_nettype wire

// ==== tb/gdmp_mcu_model.sv ====
// Controller model driving the mode, gate command and select pins
`default_nettype none
module gdmp_mcu_model (
  input wire logic pclk,
  output logic wake_in,
  output logic run_req,
  output logic [2:0] high_side_cmd,
  output logic [2:0] low_side_cmd,
  output logic sense_select_bit0,
  output logic sense_select_bit1
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {wake_in, run_req, high_side_cmd, low_side_cmd} = 8'h00;
  initial {sense_select_bit1, sense_select_bit0} = 2'h0;
  task automatic pins(logic w, logic r);
    @(posedge pclk);
    wake_in <= w;
    run_req <= r;
  endtask : pins
  task automatic cmd(logic [2:0] h, logic [2:0] l);
    @(posedge pclk);
    high_side_cmd <= h;
    low_side_cmd <= l;
  endtask : cmd
  task automatic sel(logic [1:0] s);
    @(posedge pclk);
    {sense_select_bit1, sense_select_bit0} <= s;
  endtask : sel
endmodule : gdmp_mcu_model
`default_nettype wire

// ==== tb/tb.sv ====
// Self-checking bench for the gate driver mode and protection block
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import gdmp_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, v;
  logic pready, pslverr, err, wake_in, run_req;
  logic sense_select_bit0, sense_select_bit1, phase_sense_to_gnd;
  logic [2:0] high_side_cmd, low_side_cmd;
  logic [2:0] high_side_gate_out, low_side_gate_out;
  logic gate_supply_uv = 1'b1, supply_good = 1'b0;
  logic supply_por = 1'b0, overtemp_warn = 1'b0, overcurrent = 1'b0;
  logic [5:0] drain_source_trip = 6'h00, short_monitor_en;
  logic fault_flag_low, fault_flag_high, buck_enable, regulator_enable;
  logic buck_switch_node_hiz;
  logic [1:0] phase_sense_sel;
  logic [3:0] sense_gain;
  gdmp_mode_t drive_mode;
  int miscompares = 0, comparisons = 0, id;
  integer seed = 32'hE223;
  int ids[$];
  logic [31:0] exps[$];
  string nm[9] = '{"rdata", "mode", "flags", "gates", "supply", "sense",
    "gain", "monitor", "slverr"};
  event sample_ev;
  always #2 pclk = ~pclk;
  gdmp_core #(.WAKE_FILT_CYC(20), .RUN_FILT_CYC(50)) gdmp_core_inst (.pclk,
    .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .wake_in, .run_req, .high_side_cmd, .low_side_cmd,
    .sense_select_bit0, .sense_select_bit1, .gate_supply_uv, .supply_good,
    .supply_por, .overtemp_warn, .overtemp_off(1'b0), .overcurrent,
    .drain_source_trip, .high_side_gate_out, .low_side_gate_out,
    .short_monitor_en, .fault_flag_low, .fault_flag_high, .buck_enable,
    .regulator_enable, .buck_switch_node_hiz, .phase_sense_sel,
    .phase_sense_to_gnd, .sense_gain, .drive_mode);
  gdmp_mcu_model gdmp_mcu_model_inst (.pclk, .wake_in, .run_req,
    .high_side_cmd, .low_side_cmd, .sense_select_bit0, .sense_select_bit1);
  function automatic logic [31:0] obs(int i);
    case (i)
      0: return rd;
      1: return 32'(drive_mode);
      2: return 32'({fault_flag_high, fault_flag_low});
      3: return 32'({high_side_gate_out, low_side_gate_out});
      4: return 32'({buck_switch_node_hiz, buck_enable, regulator_enable});
      5: return 32'({phase_sense_to_gnd, phase_sense_sel});
      6: return 32'(sense_gain);
      7: return 32'(short_monitor_en);
      default: return 32'(err);
    endcase
  endfunction : obs
  task automatic give_verdict();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  task automatic cmp(string n, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : cmp
  always @(sample_ev) begin
    while (ids.size() > 0) begin
      id = ids.pop_front();
      cmp(nm[id], exps.pop_front(), obs(id));
    end
  end
  task automatic note(int i, logic [31:0] e);
    ids.push_back(i);
    exps.push_back(e);
    ->sample_ev;
  endtask : note
  task automatic cyc(int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask : cyc
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 50) begin
      @(posedge pclk);
      k++;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k == 50) begin
      miscompares++;
      give_verdict();
    end
  endtask : apb
  task automatic wait_mode(gdmp_mode_t m, int lim);
    int k;
    k = 0;
    while (drive_mode !== m && k < lim) begin
      @(posedge pclk);
      k++;
    end
    #1;
    if (drive_mode !== m) begin
      miscompares++;
      give_verdict();
    end
  endtask : wait_mode
  initial begin
    #300us;
    miscompares++;
    give_verdict();
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    cyc(1);
    note(4, 32'h4);
    note(3, 32'h0);
    note(5, 32'h4);
    apb(1'b1, 12'h000, 32'hFFFF_FFF5);
    apb(1'b0, 12'h000, 32'h0);
    note(0, 32'h5);
    apb(1'b0, 12'h00C, 32'h0);
    note(8, 32'h1);
    note(0, 32'h0);
    gdmp_mcu_model_inst.pins(1'b1, 1'b0);
    cyc(10);
    gdmp_mcu_model_inst.pins(1'b0, 1'b0);
    cyc(30);
    note(1, 32'(GDMP_SLEEP));
    gdmp_mcu_model_inst.pins(1'b1, 1'b0);
    wait_mode(GDMP_WAKEUP, 100);
    cyc(2);
    note(2, 32'h3);
    note(4, 32'h3);
    @(posedge pclk);
    supply_good <= 1'b1;
    cyc(100);
    note(1, 32'(GDMP_WAKEUP));
    @(posedge pclk);
    gate_supply_uv <= 1'b0;
    wait_mode(GDMP_STANDBY, 100);
    gdmp_mcu_model_inst.cmd(3'h7, 3'h0);
    cyc(5);
    note(2, 32'h0);
    note(3, 32'h0);
    apb(1'b0, 12'h004, 32'h0);
    note(0, 32'h202);
    for (int s = 0; s < 4; s++) begin
      gdmp_mcu_model_inst.sel(s[1:0]);
      cyc(4);
      note(5, 32'(s));
    end
    gdmp_mcu_model_inst.pins(1'b1, 1'b1);
    wait_mode(GDMP_RUN, 20);
    apb(1'b1, 12'h000, 32'h9);
    apb(1'b1, 12'h008, 32'hF);
    apb(1'b0, 12'h008, 32'h0);
    note(0, 32'h5);
    note(6, 32'h5);
    repeat (8) begin
      v = $random(seed);
      gdmp_mcu_model_inst.cmd(v[2:0], v[5:3]);
      cyc(5);
      note(3, {26'h0, v[2:0] & ~v[5:3], v[5:3] & ~v[2:0]});
    end
    gdmp_mcu_model_inst.pins(1'b1, 1'b0);
    cyc(20);
    gdmp_mcu_model_inst.pins(1'b1, 1'b1);
    cyc(80);
    note(1, 32'(GDMP_RUN));
    gdmp_mcu_model_inst.cmd(3'h0, 3'h0);
    cyc(5);
    gdmp_mcu_model_inst.cmd(3'h1, 3'h0);
    cyc(1200);
    note(7, 32'h0);
    cyc(100);
    note(7, 32'h1);
    @(posedge pclk);
    drain_source_trip <= 6'h01;
    cyc(300);
    note(3, 32'h0);
    note(2, 32'h3);
    @(posedge pclk);
    drain_source_trip <= 6'h00;
    cyc(20);
    note(2, 32'h3);
    gdmp_mcu_model_inst.pins(1'b1, 1'b0);
    cyc(10);
    gdmp_mcu_model_inst.pins(1'b1, 1'b1);
    cyc(10);
    note(2, 32'h0);
    note(3, 32'h8);
    @(posedge pclk);
    gate_supply_uv <= 1'b1;
    cyc(5);
    note(2, 32'h1);
    note(3, 32'h0);
    note(4, 32'h3);
    @(posedge pclk);
    {gate_supply_uv, overtemp_warn} <= 2'h1;
    cyc(5);
    note(2, 32'h2);
    @(posedge pclk);
    {overtemp_warn, supply_por} <= 2'h1;
    cyc(6);
    note(2, 32'h3);
    @(posedge pclk);
    supply_por <= 1'b0;
    gdmp_mcu_model_inst.pins(1'b0, 1'b1);
    cyc(80);
    note(1, 32'(GDMP_RUN));
    note(3, 32'h8);
    @(posedge pclk);
    overcurrent <= 1'b1;
    cyc(2600);
    note(3, 32'h0);
    note(2, 32'h3);
    @(posedge pclk);
    overcurrent <= 1'b0;
    cyc(10);
    note(2, 32'h3);
    gdmp_mcu_model_inst.sel(2'h0);
    gdmp_mcu_model_inst.pins(1'b0, 1'b0);
    wait_mode(GDMP_SLEEP, 300);
    cyc(2);
    note(4, 32'h4);
    note(3, 32'h0);
    note(5, 32'h4);
    cyc(1);
    give_verdict();
  end
endmodule : tb
bind gdmp_core gdmp_assertions #(.WAKE_FILT_CYC(WAKE_FILT_CYC),
  .RUN_FILT_CYC(RUN_FILT_CYC)) gdmp_assertions_inst (.pclk, .presetn,
  .wake_in, .run_req, .supply_por, .high_side_cmd, .high_side_gate_out,
  .low_side_gate_out, .short_monitor_en, .fault_flag_low, .fault_flag_high,
  .buck_enable, .regulator_enable, .buck_switch_node_hiz, .drive_mode);
`default_nettype wire
